//--- src/alu8_pkg.sv
package alu8_pkg;

  // ---------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ALU8_OP_NONE  = 5'h00,
    ALU8_OP_ADD   = 5'h01,
    ALU8_OP_ADDC  = 5'h02,
    ALU8_OP_ADDW  = 5'h03,
    ALU8_OP_SUB   = 5'h04,
    ALU8_OP_SUBI  = 5'h05,
    ALU8_OP_SUBC  = 5'h06,
    ALU8_OP_SUBW  = 5'h07,
    ALU8_OP_AND   = 5'h08,
    ALU8_OP_ANDI  = 5'h09,
    ALU8_OP_OR    = 5'h0A,
    ALU8_OP_ORI   = 5'h0B,
    ALU8_OP_XOR   = 5'h0C,
    ALU8_OP_SETM  = 5'h0D,
    ALU8_OP_CLRM  = 5'h0E,
    ALU8_OP_TEST  = 5'h0F,
    ALU8_OP_MULU  = 5'h10,
    ALU8_OP_MULS  = 5'h11,
    ALU8_OP_MULSU = 5'h12,
    ALU8_OP_FMULU = 5'h13,
    ALU8_OP_FMULS = 5'h14,
    ALU8_OP_FMSU  = 5'h15
  } alu8_op_e;

  typedef enum logic [0:0] {
    ALU8_ST_IDLE = 1'b0,
    ALU8_ST_BUSY = 1'b1
  } alu8_state_e;

  // ---------------------------------------------------------------
  // Status flag positions and constants
  // ---------------------------------------------------------------
  localparam int ALU8_FLG_NIL = 0;
  localparam int ALU8_FLG_BORROW = 1;
  localparam int ALU8_FLG_MSB = 2;
  localparam int ALU8_FLG_WRAP = 3;
  localparam int ALU8_FLG_POL = 4;
  localparam int ALU8_FLG_HALF = 5;
  localparam int ALU8_FLG_W = 6;
  localparam logic [5:0] ALU8_FLG_RST = 6'h00;
  localparam logic [7:0] ALU8_BYTE_ZERO = 8'h00;
  localparam logic [15:0] ALU8_WORD_ZERO = 16'h0000;

endpackage : alu8_pkg

//--- src/alu8_core.sv
`timescale 1ns/1ps
module alu8_core
  import alu8_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire alu8_op_e op_i,
  input wire logic [7:0] target_i,
  input wire logic [7:0] target_hi_i,
  input wire logic [7:0] operand_i,
  input wire logic [7:0] literal_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] result_o,
  output logic [7:0] result_hi_o,
  output logic wr_target_o,
  output logic wr_pair_o,
  output logic wr_product_o,
  output logic [15:0] product_o,
  output logic [ALU8_FLG_W-1:0] flags_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_two_cycle(input alu8_op_e op);
    is_two_cycle = (op == ALU8_OP_ADDW) || (op == ALU8_OP_SUBW) || (op >= ALU8_OP_MULU);
  endfunction : is_two_cycle

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  alu8_state_e state_reg, state_next;
  logic [ALU8_FLG_W-1:0] flags_reg, flags_next;
  logic [7:0] res_reg, res_next, reshi_reg, reshi_next;
  logic [15:0] prod_reg, prod_next;
  logic done_reg, done_next, wt_reg, wt_next, wp_reg, wp_next, wm_reg, wm_next;
  alu8_op_e op_reg, op_next;
  logic [7:0] a_reg, a_next, ah_reg, ah_next, b_reg, b_next;

  logic [8:0] sum9;
  logic [4:0] half5;
  logic [15:0] word16;
  logic [16:0] wide17;
  logic signed [17:0] mul18;
  logic [15:0] mulp;
  logic cin;
  logic [7:0] bop;

  always_comb begin
    state_next = state_reg;
    flags_next = flags_reg;
    res_next = res_reg;
    reshi_next = reshi_reg;
    prod_next = prod_reg;
    op_next = op_reg;
    a_next = a_reg;
    ah_next = ah_reg;
    b_next = b_reg;
    done_next = 1'b0;
    wt_next = 1'b0;
    wp_next = 1'b0;
    wm_next = 1'b0;
    cin = flags_reg[ALU8_FLG_BORROW];
    bop = (op_i == ALU8_OP_SUBI) ? literal_i : operand_i;
    sum9 = 9'h000;
    half5 = 5'h00;
    word16 = ALU8_WORD_ZERO;
    wide17 = 17'h00000;
    mul18 = 18'sh00000;
    mulp = ALU8_WORD_ZERO;
    case (state_reg)
      ALU8_ST_IDLE: begin
        if (start_i && is_two_cycle(op_i)) begin
          // Second cycle finishes the wide ops
          state_next = ALU8_ST_BUSY;
          op_next = op_i;
          a_next = target_i;
          ah_next = target_hi_i;
          b_next = (op_i >= ALU8_OP_MULU) ? operand_i : literal_i;
        end else if (start_i) begin
          case (op_i)
            ALU8_OP_ADD, ALU8_OP_ADDC: begin
              sum9 = {1'b0, target_i} + {1'b0, operand_i}
                + {8'h00, (op_i == ALU8_OP_ADDC) & cin};
              half5 = {1'b0, target_i[3:0]} + {1'b0, operand_i[3:0]}
                + {4'h0, (op_i == ALU8_OP_ADDC) & cin};
              res_next = sum9[7:0];
              flags_next[ALU8_FLG_BORROW] = sum9[8];
              flags_next[ALU8_FLG_HALF] = half5[4];
              flags_next[ALU8_FLG_WRAP] = (target_i[7] == operand_i[7])
                && (sum9[7] != target_i[7]);
            end
            ALU8_OP_SUB, ALU8_OP_SUBI, ALU8_OP_SUBC: begin
              sum9 = {1'b0, target_i} - {1'b0, bop}
                - {8'h00, (op_i == ALU8_OP_SUBC) & cin};
              half5 = {1'b0, target_i[3:0]} - {1'b0, bop[3:0]}
                - {4'h0, (op_i == ALU8_OP_SUBC) & cin};
              res_next = sum9[7:0];
              flags_next[ALU8_FLG_BORROW] = sum9[8];
              flags_next[ALU8_FLG_HALF] = half5[4];
              flags_next[ALU8_FLG_WRAP] = (target_i[7] != bop[7])
                && (sum9[7] != target_i[7]);
            end
            default: begin
              case (op_i)
                ALU8_OP_AND: res_next = target_i & operand_i;
                ALU8_OP_ANDI: res_next = target_i & literal_i;
                ALU8_OP_OR: res_next = target_i | operand_i;
                ALU8_OP_ORI, ALU8_OP_SETM: res_next = target_i | literal_i;
                ALU8_OP_XOR: res_next = target_i ^ operand_i;
                ALU8_OP_CLRM: res_next = target_i & ~literal_i;
                default: res_next = target_i;
              endcase
              flags_next[ALU8_FLG_WRAP] = 1'b0;
            end
          endcase
          if (op_i != ALU8_OP_NONE) begin
            flags_next[ALU8_FLG_NIL] = (res_next == ALU8_BYTE_ZERO);
            flags_next[ALU8_FLG_MSB] = res_next[7];
            done_next = 1'b1;
            wt_next = (op_i != ALU8_OP_TEST);
          end else begin
            flags_next = flags_reg;
            res_next = res_reg;
          end
        end
      end
      ALU8_ST_BUSY: begin
        state_next = ALU8_ST_IDLE;
        done_next = 1'b1;
        if (op_reg == ALU8_OP_ADDW || op_reg == ALU8_OP_SUBW) begin
          wide17 = (op_reg == ALU8_OP_ADDW)
            ? ({1'b0, ah_reg, a_reg} + {9'h000, b_reg})
            : ({1'b0, ah_reg, a_reg} - {9'h000, b_reg});
          word16 = wide17[15:0];
          res_next = word16[7:0];
          reshi_next = word16[15:8];
          wp_next = 1'b1;
          flags_next[ALU8_FLG_NIL] = (word16 == ALU8_WORD_ZERO);
          flags_next[ALU8_FLG_BORROW] = wide17[16];
          flags_next[ALU8_FLG_MSB] = word16[15];
          flags_next[ALU8_FLG_WRAP] = (op_reg == ALU8_OP_ADDW)
            ? (~ah_reg[7] & word16[15]) : (ah_reg[7] & ~word16[15]);
          flags_next[ALU8_FLG_POL] = word16[15] ^ flags_next[ALU8_FLG_WRAP];
        end else begin
          case (op_reg)
            ALU8_OP_MULS, ALU8_OP_FMULS:
              mul18 = $signed({{2{a_reg[7]}}, a_reg}) * $signed({{2{b_reg[7]}}, b_reg});
            ALU8_OP_MULSU, ALU8_OP_FMSU:
              mul18 = $signed({{2{a_reg[7]}}, a_reg}) * $signed({2'b00, b_reg});
            default:
              mul18 = $signed({2'b00, a_reg}) * $signed({2'b00, b_reg});
          endcase
          mulp = mul18[15:0];
          flags_next[ALU8_FLG_BORROW] = mulp[15];
          if (op_reg >= ALU8_OP_FMULU) begin
            mulp = {mulp[14:0], 1'b0};
          end
          prod_next = mulp;
          flags_next[ALU8_FLG_NIL] = (mulp == ALU8_WORD_ZERO);
          wm_next = 1'b1;
        end
      end
      default: state_next = ALU8_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ALU8_ST_IDLE;
      flags_reg <= ALU8_FLG_RST;
      res_reg <= ALU8_BYTE_ZERO;
      reshi_reg <= ALU8_BYTE_ZERO;
      prod_reg <= ALU8_WORD_ZERO;
      op_reg <= ALU8_OP_NONE;
      a_reg <= ALU8_BYTE_ZERO;
      ah_reg <= ALU8_BYTE_ZERO;
      b_reg <= ALU8_BYTE_ZERO;
      done_reg <= 1'b0;
      wt_reg <= 1'b0;
      wp_reg <= 1'b0;
      wm_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      flags_reg <= flags_next;
      res_reg <= res_next;
      reshi_reg <= reshi_next;
      prod_reg <= prod_next;
      op_reg <= op_next;
      a_reg <= a_next;
      ah_reg <= ah_next;
      b_reg <= b_next;
      done_reg <= done_next;
      wt_reg <= wt_next;
      wp_reg <= wp_next;
      wm_reg <= wm_next;
    end
  end

  // Busy blocks a new start while the wide op finishes
  assign busy_o = (state_reg == ALU8_ST_BUSY);
  assign done_o = done_reg;
  assign result_o = res_reg;
  assign result_hi_o = reshi_reg;
  assign wr_target_o = wt_reg;
  assign wr_pair_o = wp_reg;
  assign wr_product_o = wm_reg;
  assign product_o = prod_reg;
  assign flags_o = flags_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_wide_start;
    start_i && !busy_o && is_two_cycle(op_i);
  endsequence

  a_wide_two_clocks: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wide_start |=> busy_o ##1 (done_o && !busy_o))
    else $error("wide op did not finish in 2 clocks");
  a_single_one_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o && !is_two_cycle(op_i) && op_i != ALU8_OP_NONE) |=> done_o && !busy_o)
    else $error("single op not done in 1 clock");
  a_add_result: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o && op_i == ALU8_OP_ADD) |=>
    result_o == $past(target_i) + $past(operand_i))
    else $error("add result wrong");
  a_sub_result: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o && op_i == ALU8_OP_SUB) |=>
    result_o == $past(target_i) - $past(operand_i))
    else $error("subtract result wrong");
  a_clrm_result: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o && op_i == ALU8_OP_CLRM) |=>
    result_o == ($past(target_i) & ~$past(literal_i)))
    else $error("bit clear wrong");
  a_logic_keep_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o && op_i == ALU8_OP_AND) |=>
    flags_o[ALU8_FLG_BORROW] == $past(flags_o[ALU8_FLG_BORROW]) && !flags_o[ALU8_FLG_WRAP])
    else $error("logic op touched carry");
  a_test_nowrite: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o && op_i == ALU8_OP_TEST) |=>
    !wr_target_o && flags_o[ALU8_FLG_NIL] == ($past(target_i) == ALU8_BYTE_ZERO))
    else $error("test wrong");
  a_mul_product: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o && op_i == ALU8_OP_MULU) |=> ##1
    product_o == {8'h00, $past(target_i, 2)} * {8'h00, $past(operand_i, 2)} && wr_product_o)
    else $error("unsigned product wrong");
  a_frac_lsb: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_product_o && $past(op_reg) >= ALU8_OP_FMULU) |-> !product_o[0])
    else $error("fractional product not shifted");
  a_pol_derived: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_pair_o |-> flags_o[ALU8_FLG_POL] == (flags_o[ALU8_FLG_MSB] ^ flags_o[ALU8_FLG_WRAP]))
    else $error("polarity not msb xor wrap");
  a_wsub_result: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o && op_i == ALU8_OP_SUBW) |=> ##1
    {result_hi_o, result_o} ==
    {$past(target_hi_i, 2), $past(target_i, 2)} - {8'h00, $past(literal_i, 2)})
    else $error("word subtract wrong");

endmodule : alu8_core

//--- test/alu8_regfile_model.sv
`timescale 1ns/1ps
module alu8_regfile_model
  import alu8_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_target_i,
  input wire logic wr_pair_i,
  input wire logic wr_product_i,
  input wire logic [7:0] result_i,
  input wire logic [7:0] result_hi_i,
  input wire logic [15:0] product_i,
  output logic [7:0] target_o,
  output logic [15:0] pair_o,
  output logic [15:0] product_o
);
  // ---------------------------------------------------------------
  // Write-back side of the working registers
  // ---------------------------------------------------------------
  // Strobes are one cycle, so only the strobe edge may capture
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      target_o <= ALU8_BYTE_ZERO;
      pair_o <= ALU8_WORD_ZERO;
      product_o <= ALU8_WORD_ZERO;
    end else begin
      if (wr_target_i) target_o <= result_i;
      if (wr_pair_i) pair_o <= {result_hi_i, result_i};
      if (wr_product_i) product_o <= product_i;
    end
  end
endmodule : alu8_regfile_model

//--- test/tb_arith_logic_unit_8bit.sv
`timescale 1ns/1ps
module tb_arith_logic_unit_8bit
  import alu8_pkg::*;
;
  typedef struct {
    logic [7:0] res;
    logic [7:0] hi;
    logic [15:0] prod;
    logic [5:0] fl;
    logic [2:0] st;
    int kind;
    int lat;
    int take;
  } alu8_exp_s;
  logic clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0;
  alu8_op_e op_i = ALU8_OP_NONE;
  logic [7:0] target_i = 8'h00, target_hi_i = 8'h00, operand_i = 8'h00, literal_i = 8'h00;
  logic busy_o, done_o, wr_target_o, wr_pair_o, wr_product_o;
  logic [7:0] result_o, result_hi_o;
  logic [15:0] product_o;
  logic [5:0] flags_o, fl_model = ALU8_FLG_RST;
  logic [7:0] reg_target;
  logic [15:0] reg_pair, reg_product;
  alu8_exp_s last;
  logic last_ok = 1'b0;
  int n_errors = 0, total_checks = 0, cyc = 0, seed = 76;
  alu8_exp_s exp_q[$];
  alu8_exp_s got;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  alu8_core DUT (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
    .target_i(target_i), .target_hi_i(target_hi_i), .operand_i(operand_i),
    .literal_i(literal_i), .busy_o(busy_o), .done_o(done_o), .result_o(result_o),
    .result_hi_o(result_hi_o), .wr_target_o(wr_target_o), .wr_pair_o(wr_pair_o),
    .wr_product_o(wr_product_o), .product_o(product_o), .flags_o(flags_o));
  alu8_regfile_model u_regs (.clk_i(clk_i), .rst_i(rst_i), .wr_target_i(wr_target_o),
    .wr_pair_i(wr_pair_o), .wr_product_i(wr_product_o), .result_i(result_o),
    .result_hi_i(result_hi_o), .product_i(product_o), .target_o(reg_target),
    .pair_o(reg_pair), .product_o(reg_product));
  // ---------------------------------------------------------------
  // Expected results and flags
  // ---------------------------------------------------------------
  function automatic alu8_exp_s model(alu8_op_e op, logic [7:0] t, logic [7:0] th,
                                      logic [7:0] o, logic [7:0] l, logic [5:0] fi);
    alu8_exp_s e;
    logic [8:0] s9;
    logic [4:0] h5;
    logic [16:0] w;
    logic [31:0] p;
    logic [7:0] s;
    logic ci;
    e = '{res: 8'h00, hi: 8'h00, prod: 16'h0000, fl: fi, st: 3'h1, kind: 0, lat: 1, take: 0};
    ci = fi[ALU8_FLG_BORROW] & (op == ALU8_OP_ADDC || op == ALU8_OP_SUBC);
    s = (op == ALU8_OP_SUBI || op == ALU8_OP_ANDI || op == ALU8_OP_ORI) ? l : o;
    case (op)
      ALU8_OP_ADD, ALU8_OP_ADDC: begin
        s9 = {1'b0, t} + {1'b0, o} + {8'h00, ci};
        h5 = {1'b0, t[3:0]} + {1'b0, o[3:0]} + {4'h0, ci};
        e.fl[ALU8_FLG_WRAP] = (t[7] == o[7]) && (s9[7] != t[7]);
      end
      ALU8_OP_SUB, ALU8_OP_SUBI, ALU8_OP_SUBC: begin
        s9 = {1'b0, t} - {1'b0, s} - {8'h00, ci};
        h5 = {1'b0, t[3:0]} - {1'b0, s[3:0]} - {4'h0, ci};
        e.fl[ALU8_FLG_WRAP] = (t[7] != s[7]) && (s9[7] != t[7]);
      end
      ALU8_OP_ADDW, ALU8_OP_SUBW: begin
        w = (op == ALU8_OP_ADDW) ? {1'b0, th, t} + {9'h000, l} : {1'b0, th, t} - {9'h000, l};
        e = '{res: w[7:0], hi: w[15:8], prod: 16'h0000, fl: fi, st: 3'h2, kind: 1, lat: 2,
              take: 0};
        e.fl[ALU8_FLG_NIL] = (w[15:0] == 16'h0000);
        e.fl[ALU8_FLG_BORROW] = w[16];
        e.fl[ALU8_FLG_MSB] = w[15];
        e.fl[ALU8_FLG_WRAP] = (op == ALU8_OP_ADDW) ? (~th[7] & w[15]) : (th[7] & ~w[15]);
        e.fl[ALU8_FLG_POL] = w[15] ^ e.fl[ALU8_FLG_WRAP];
        return e;
      end
      ALU8_OP_AND, ALU8_OP_ANDI: s9 = {1'b0, t & s};
      ALU8_OP_OR, ALU8_OP_ORI: s9 = {1'b0, t | s};
      ALU8_OP_XOR: s9 = {1'b0, t ^ o};
      ALU8_OP_SETM: s9 = {1'b0, t | l};
      ALU8_OP_CLRM: s9 = {1'b0, t & ~l};
      ALU8_OP_TEST: begin
        s9 = {1'b0, t};
        e.st = 3'h0;
        e.kind = 3;
      end
      default: begin
        // Explicit extension keeps the signed forms out of unsigned context
        if (op == ALU8_OP_MULU || op == ALU8_OP_FMULU) begin
          p = {24'h000000, t} * {24'h000000, o};
        end else if (op == ALU8_OP_MULS || op == ALU8_OP_FMULS) begin
          p = {{24{t[7]}}, t} * {{24{o[7]}}, o};
        end else begin
          p = {{24{t[7]}}, t} * {24'h000000, o};
        end
        e = '{res: 8'h00, hi: 8'h00, prod: p[15:0], fl: fi, st: 3'h4, kind: 2, lat: 2,
              take: 0};
        e.fl[ALU8_FLG_BORROW] = p[15];
        if (op >= ALU8_OP_FMULU) e.prod = {p[14:0], 1'b0};
        e.fl[ALU8_FLG_NIL] = (e.prod == 16'h0000);
        return e;
      end
    endcase
    e.res = s9[7:0];
    e.fl[ALU8_FLG_NIL] = (s9[7:0] == 8'h00);
    e.fl[ALU8_FLG_MSB] = s9[7];
    if (op <= ALU8_OP_SUBC) begin
      e.fl[ALU8_FLG_BORROW] = s9[8];
      e.fl[ALU8_FLG_HALF] = h5[4];
    end else begin
      e.fl[ALU8_FLG_WRAP] = 1'b0;
    end
    return e;
  endfunction : model
  // ---------------------------------------------------------------
  // Driver and checker
  // ---------------------------------------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, expv, seen);
    end
  endtask : check
  task automatic issue(alu8_op_e op);
    alu8_exp_s e;
    @(posedge clk_i);
    start_i <= 1'b1;
    op_i <= op;
    target_i <= 8'($random(seed));
    target_hi_i <= 8'($random(seed));
    operand_i <= 8'($random(seed));
    literal_i <= 8'($random(seed));
    #1;
    if (op == ALU8_OP_NONE) return;
    e = model(op, target_i, target_hi_i, operand_i, literal_i, fl_model);
    // Cycle in which the request stands
    e.take = cyc;
    fl_model = e.fl;
    exp_q.push_back(e);
    if (e.lat == 2) begin
      @(posedge clk_i);
      // Start while busy must be ignored
      start_i <= 1'($random(seed));
      op_i <= ALU8_OP_ADD;
      #1;
      check("busy_o", 32'(busy_o), 32'h1);
    end
  endtask : issue
  always @(negedge clk_i) begin
    // Register file takes the result on the edge after done
    if (last_ok) begin
      last_ok = 1'b0;
      if (last.kind == 0) check("reg_target", 32'(reg_target), 32'(last.res));
      if (last.kind == 1) check("reg_pair", 32'(reg_pair), 32'({last.hi, last.res}));
      if (last.kind == 2) check("reg_product", 32'(reg_product), 32'(last.prod));
    end
    if (!rst_i && done_o) begin
      if (exp_q.size() == 0) begin
        check("done_o", 32'(done_o), 32'h0);
      end else begin
        got = exp_q.pop_front();
        last = got;
        last_ok = 1'b1;
        check("busy_o", 32'(busy_o), 32'h0);
        check("latency", cyc - got.take, got.lat);
        check("flags_o", 32'(flags_o), 32'(got.fl));
        check("strobes", 32'({wr_product_o, wr_pair_o, wr_target_o}), 32'(got.st));
        if (got.kind < 2) check("result_o", 32'(result_o), 32'(got.res));
        if (got.kind == 1) check("result_hi_o", 32'(result_hi_o), 32'(got.hi));
        if (got.kind == 2) check("product_o", 32'(product_o), 32'(got.prod));
      end
    end
  end
  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    conclude();
  end
  // ---------------------------------------------------------------
  // Main sequence: every code in order, then random mix
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i <= 21; i++) issue(alu8_op_e'(i));
    for (int i = 0; i < 2000; i++) issue(alu8_op_e'(5'($unsigned($random(seed)) % 22)));
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("pending", exp_q.size(), 0);
    conclude();
  end
endmodule : tb_arith_logic_unit_8bit
